// *** hdl/cgir_pkg.sv ***
// Constants shared by the clock generator identity and control registers
package cgir_pkg;
   // ----------------------------------------------------------------
   // Register indices and byte addresses
   // ----------------------------------------------------------------
   localparam logic [5:0] IDX_VENDOR_REV = 6'h07;
   localparam logic [5:0] IDX_VARIANT_SE = 6'h08;
   localparam logic [5:0] IDX_OUT_CTRL = 6'h09;
   localparam logic [5:0] IDX_HOST_STOP = 6'h0a;
   localparam logic [5:0] IDX_MGMT = 6'h0b;
   localparam logic [5:0] IDX_BYTE_COUNT = 6'h0c;
   localparam logic [5:0] IDX_BLOCK_READ = 6'h10;
   localparam logic [5:0] IDX_HIGHEST = 6'h0c;
   localparam logic [1:0] ADDR_LOW_ZERO = 2'h0;
   // ----------------------------------------------------------------
   // Timing counts
   // ----------------------------------------------------------------
   // Enabled edges after reset until the pin synchroniser holds pin levels
   localparam logic [1:0] SYNC_FILL = 2'h2;
   // ----------------------------------------------------------------
   // Writable bit masks per byte
   // ----------------------------------------------------------------
   localparam logic [7:0] MASK_VARIANT_SE = 8'h0f;
   localparam logic [7:0] MASK_OUT_CTRL = 8'hbf;
   localparam logic [7:0] MASK_HOST_STOP = 8'h7f;
   localparam logic [7:0] MASK_MGMT = 8'hfd;
   localparam logic [7:0] MASK_BYTE_COUNT = 8'hff;
   // ----------------------------------------------------------------
   // Reset values of the stored bits
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_VARIANT_SE = 8'h00;
   localparam logic [7:0] RST_OUT_CTRL = 8'h25;
   localparam logic [7:0] RST_HOST_STOP = 8'h03;
   localparam logic [7:0] RST_MGMT = 8'h05;
   localparam logic [7:0] RST_BYTE_COUNT = 8'h0d;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int SE_A_BIT = 1;
   localparam int SE_B_BIT = 0;
   localparam int PERIPH_HALT_BIT = 7;
   localparam int TRUSTED_BIT = 6;
   localparam int REF_STRENGTH_BIT = 5;
   localparam int TEST_SELECT_BIT = 4;
   localparam int TEST_ENTRY_BIT = 3;
   localparam int IO_VOLT_MSB = 2;
   localparam int SREF5_BIT = 7;
   localparam int PAIR1_HALT_BIT = 1;
   localparam int PAIR0_HALT_BIT = 0;
   localparam int DEBUG_RUN_BIT = 3;
   localparam int PAIR1_RUN_BIT = 2;
   localparam int GEN2_BIT = 1;
   localparam int DEBUG_HALT_BIT = 0;
   localparam int COUNT_MSB = 5;
   localparam int LAST_FLAG_BIT = 8;
   // ----------------------------------------------------------------
   // Bus encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'h0;
   // Bus slave states
   typedef enum logic {CG_IDLE, CG_DATA} cgir_state_t;
endpackage

// *** hdl/cgir_regs.sv ***
// Identity and output control register bank with AHB-Lite slave
// Bus timing
// A transfer taken in its address phase gets exactly one wait state:
// ready drops for the cycle after the address phase and rises again
// once the data phase has completed. Read data is registered at that
// same edge and stands until the next transfer completes. Writes land
// at the end of the wait state, so a read right behind a write already
// returns the new value.
//
// Addressing
// Each register is one byte in bits 7..0 of an aligned word; the upper
// bits read as zero. Unmapped or unaligned addresses still get OKAY:
// writes are dropped there and reads return zero.
//
// Block read
// A window word hands out the bytes one per read, from byte zero on.
// Bit 8 marks the last byte of the programmed count, after which the
// pointer wraps. Any write to the window restarts it; a count of zero
// acts as one. Bytes below the first register read as zero.
// The pointer is shared, so two masters reading the window at once
// would interleave their sequences.
//
// Straps and pins
// The trusted and SREF5 straps are latched once, when the synchroniser has filled
// after reset; until then bytes 9 and 10 show zero in those bits.
// Stop, management and test pins pass two flops and the output flop,
// so they act three enabled cycles after they change.
// With CE low every flop, the bus slave included, holds still.
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cgir_regs #(
   parameter logic [3:0] REVISION_CODE = 4'h0, // Arbitrary value
   parameter logic [3:0] VENDOR_CODE = 4'h6, // Arbitrary value
   parameter logic [3:0] VARIANT_CODE = 4'h3, // Arbitrary value
   parameter logic GEN2_STATUS = 1'h0,
   parameter int PAIRS = 3
) (
   // Clock, reset, enable
   input wire logic MCLK,
   input wire logic ARST_N,
   input wire logic CE,
   // AHB-Lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic HREADYOUT,
   output logic HRESP,
   output logic [31:0] HRDATA,
   // Pins from outside
   input wire logic TRUSTED_STRAP,
   input wire logic SREF5_STRAP,
   input wire logic TEST_MODE_STRAP,
   input wire logic TEST_SEL_STRAP,
   input wire logic PERIPH_STOP,
   input wire logic HOST_STOP,
   input wire logic MGMT_M1,
   // Clock control outputs
   output logic SE_A_ENABLE,
   output logic SE_B_ENABLE,
   output logic PERIPH5_HALT,
   output logic [PAIRS-1:0] PAIR_RUN,
   output logic REF_DOUBLE_DRIVE,
   output logic TEST_MODE_ACTIVE,
   output logic TEST_OUT_DIVIDED,
   output logic [2:0] IO_VOLT_CODE
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   cgir_pkg::cgir_state_t state;
   logic [5:0] req_idx;
   logic req_write;
   logic req_ok;
   logic [7:0] variant_se;
   logic [7:0] out_ctrl;
   logic [7:0] host_stop;
   logic [7:0] mgmt;
   logic [7:0] byte_count;
   logic trusted_latch;
   logic sref5_latch;
   logic [1:0] strap_fill;
   logic [5:0] blk_ptr;
   logic [6:0] sync_a;
   logic [6:0] sync_b;
   logic take;
   logic commit;
   logic blk_last;
   logic [5:0] next_blk_ptr;
   logic [7:0] blk_byte;
   logic [PAIRS-1:0] halt_allow;
   logic [PAIRS-1:0] m1_run;

   // Transfer accepted in its address phase; only NONSEQ starts one, as
   // the bus carries single words and never bursts
   assign take = CE && HSEL && HREADY && HTRANS == cgir_pkg::HTRANS_NONSEQ;
   // Data phase wait cycle completes the transfer
   // Every register write and read keys off this one strobe
   assign commit = CE && state == cgir_pkg::CG_DATA;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Two flops per pin; only the second stage is read
   // Reset clears both stages, so pins read as inactive until they fill
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         sync_a <= 7'h00;
         sync_b <= 7'h00;
      end else if (CE) begin
         sync_a <= {TRUSTED_STRAP, SREF5_STRAP, TEST_MODE_STRAP,
                    TEST_SEL_STRAP, PERIPH_STOP, HOST_STOP, MGMT_M1};
         sync_b <= sync_a;
      end
   end

   // Counts enabled edges since reset and stops one past the fill point.
   // The synchroniser is cleared by reset, so latching any earlier would
   // catch its zeros instead of the strap levels.
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         strap_fill <= 2'h0;
      end else if (CE && strap_fill <= cgir_pkg::SYNC_FILL) begin
         strap_fill <= strap_fill + 2'h1;
      end
   end

   // Straps are caught once, when the second stage holds the pin levels;
   // a transfer in flight does not delay this, so no strap is missed
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         trusted_latch <= 1'h0;
         sref5_latch <= 1'h0;
      end else if (CE && strap_fill == cgir_pkg::SYNC_FILL) begin
         trusted_latch <= sync_b[6];
         sref5_latch <= sync_b[5];
      end
   end

   // ----------------------------------------------------------------
   // AHB-Lite slave
   // ----------------------------------------------------------------
   // One wait state per transfer, so a read right after a write sees it
   // HSIZE is ignored; every register is a whole word on the bus
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state <= cgir_pkg::CG_IDLE;
         HREADYOUT <= 1'h1;
         req_idx <= 6'h00;
         req_write <= 1'h0;
         req_ok <= 1'h0;
      end else if (CE) begin
         case (state)
            cgir_pkg::CG_IDLE: begin
               if (take) begin
                  state <= cgir_pkg::CG_DATA;
                  HREADYOUT <= 1'h0;
                  req_idx <= HADDR[7:2];
                  req_write <= HWRITE;
                  req_ok <= HADDR[31:8] == 24'h000000 &&
                            HADDR[1:0] == cgir_pkg::ADDR_LOW_ZERO;
               end
            end
            cgir_pkg::CG_DATA: begin
               // Completion edge: ready returns for the master to sample
               state <= cgir_pkg::CG_IDLE;
               HREADYOUT <= 1'h1;
            end
            default: begin
               state <= cgir_pkg::CG_IDLE;
               HREADYOUT <= 1'h1;
            end
         endcase
      end
   end

   // Every answer is OKAY; unmapped reads give zero
   // No error response exists, the flop only keeps the output registered
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         HRESP <= cgir_pkg::HRESP_OKAY;
      end else begin
         HRESP <= cgir_pkg::HRESP_OKAY;
      end
   end

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   // Masks clear the read-only positions, so the stored copies stay zero
   // and the read path merges the live status in without a conflict
   // reserved bits store what is written; identity bits never do
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         variant_se <= cgir_pkg::RST_VARIANT_SE;
         out_ctrl <= cgir_pkg::RST_OUT_CTRL;
         host_stop <= cgir_pkg::RST_HOST_STOP;
         mgmt <= cgir_pkg::RST_MGMT;
         byte_count <= cgir_pkg::RST_BYTE_COUNT;
      end else if (commit && req_write && req_ok) begin
         case (req_idx)
            cgir_pkg::IDX_VARIANT_SE:
               variant_se <= HWDATA[7:0] & cgir_pkg::MASK_VARIANT_SE;
            cgir_pkg::IDX_OUT_CTRL:
               out_ctrl <= HWDATA[7:0] & cgir_pkg::MASK_OUT_CTRL;
            cgir_pkg::IDX_HOST_STOP:
               host_stop <= HWDATA[7:0] & cgir_pkg::MASK_HOST_STOP;
            cgir_pkg::IDX_MGMT:
               mgmt <= HWDATA[7:0] & cgir_pkg::MASK_MGMT;
            cgir_pkg::IDX_BYTE_COUNT:
               byte_count <= HWDATA[7:0] & cgir_pkg::MASK_BYTE_COUNT;
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Read composition
   // ----------------------------------------------------------------
   // Byte view as software sees it; read-only fields are merged in here
   // rather than stored, so no write can ever disturb them
   function automatic logic [7:0] byte_at(input logic [5:0] idx);
      logic [7:0] v;
      v = 8'h00;
      case (idx)
         cgir_pkg::IDX_VENDOR_REV: v = {REVISION_CODE, VENDOR_CODE};
         // variant code in the top nibble
         cgir_pkg::IDX_VARIANT_SE: v = {VARIANT_CODE, variant_se[3:0]};
         cgir_pkg::IDX_OUT_CTRL: begin
            v = out_ctrl;
            v[cgir_pkg::TRUSTED_BIT] = trusted_latch;
         end
         cgir_pkg::IDX_HOST_STOP: begin
            v = host_stop;
            v[cgir_pkg::SREF5_BIT] = sref5_latch;
         end
         cgir_pkg::IDX_MGMT: begin
            v = mgmt;
            v[cgir_pkg::GEN2_BIT] = GEN2_STATUS;
         end
         cgir_pkg::IDX_BYTE_COUNT: v = byte_count;
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // block read stops at the programmed count, then starts over.
   // The compare runs one bit wider, so a count of 63 still ends on the
   // last byte instead of the pointer wrapping early.
   always_comb begin
      blk_byte = byte_at(blk_ptr);
      blk_last = 7'(blk_ptr) + 7'h01 >=
                 {1'h0, byte_count[cgir_pkg::COUNT_MSB:0]};
      next_blk_ptr = blk_last ? 6'h00 : blk_ptr + 6'h01;
   end

   // Read data registered at the end of the wait state
   // Writes and refused reads clear it, so stale data never looks valid
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         HRDATA <= 32'h00000000;
      end else if (commit) begin
         if (req_write || !req_ok) begin
            HRDATA <= 32'h00000000;
         end else if (req_idx == cgir_pkg::IDX_BLOCK_READ) begin
            HRDATA <= {23'h000000, blk_last, blk_byte};
         end else begin
            HRDATA <= {24'h000000, byte_at(req_idx)};
         end
      end
   end

   // Block pointer; a write to the window restarts the sequence
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         blk_ptr <= 6'h00;
      end else if (commit && req_ok &&
                   req_idx == cgir_pkg::IDX_BLOCK_READ) begin
         blk_ptr <= req_write ? 6'h00 : next_blk_ptr;
      end
   end

   // ----------------------------------------------------------------
   // Clock control outputs
   // ----------------------------------------------------------------
   // Haltable bits per pair: pairs zero and one from the stop register,
   // the debug pair from the management register
   assign halt_allow = {mgmt[cgir_pkg::DEBUG_HALT_BIT],
                        host_stop[cgir_pkg::PAIR1_HALT_BIT],
                        host_stop[cgir_pkg::PAIR0_HALT_BIT]};
   // Pair zero has no management bit, so it keeps running in M1
   assign m1_run = {mgmt[cgir_pkg::DEBUG_RUN_BIT],
                    mgmt[cgir_pkg::PAIR1_RUN_BIT], 1'h1};

   // Per pair: stop when haltable and stopped, or off in M1 with its run bit clear
   // M1 turns off a pair whose run bit is clear, whatever its halt bit says
   genvar p;
   generate
      for (p = 0; p < PAIRS; p = p + 1) begin : g_pair
         always_ff @(posedge MCLK or negedge ARST_N) begin
            if (!ARST_N) begin
               PAIR_RUN[p] <= 1'h1;
            end else if (CE) begin
               PAIR_RUN[p] <= !(halt_allow[p] && sync_b[1]) &&
                              !(sync_b[0] && !m1_run[p]);
            end
         end
      end
   endgenerate

   // Remaining control outputs, registered
   // Registered so no output glitches while a byte is being rewritten
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         SE_A_ENABLE <= 1'h0;
         SE_B_ENABLE <= 1'h0;
         PERIPH5_HALT <= 1'h0;
         REF_DOUBLE_DRIVE <= 1'h1;
         TEST_MODE_ACTIVE <= 1'h0;
         TEST_OUT_DIVIDED <= 1'h0;
         IO_VOLT_CODE <= 3'h5;
      end else if (CE) begin
         SE_A_ENABLE <= variant_se[cgir_pkg::SE_A_BIT];
         SE_B_ENABLE <= variant_se[cgir_pkg::SE_B_BIT];
         // free clock five halts only if allowed
         PERIPH5_HALT <= out_ctrl[cgir_pkg::PERIPH_HALT_BIT] && sync_b[2];
         REF_DOUBLE_DRIVE <= out_ctrl[cgir_pkg::REF_STRENGTH_BIT];
         TEST_MODE_ACTIVE <= out_ctrl[cgir_pkg::TEST_ENTRY_BIT] || sync_b[4];
         // register select replaces the select strap while test entry is set
         TEST_OUT_DIVIDED <= out_ctrl[cgir_pkg::TEST_ENTRY_BIT] ?
                             out_ctrl[cgir_pkg::TEST_SELECT_BIT] : sync_b[3];
         IO_VOLT_CODE <= out_ctrl[cgir_pkg::IO_VOLT_MSB:0];
      end
   end
endmodule
`default_nettype wire

// *** tb/cgir_host.sv ***
// Bus master model standing in for the management host
`timescale 1ns/1ps
`default_nettype none
module cgir_host (
   // Clock and answer
   input wire logic MCLK,
   input wire logic HREADY,
   input wire logic [31:0] HRDATA,
   // Request
   output logic HSEL,
   output logic [31:0] HADDR,
   output logic [1:0] HTRANS,
   output logic HWRITE,
   output logic [2:0] HSIZE,
   output logic [31:0] HWDATA
);
   // Idle bus at time zero
   initial begin
      HSEL = 1'b0;
      HADDR = 32'h0;
      HTRANS = 2'h0;
      HWRITE = 1'b0;
      HSIZE = 3'h2;
      HWDATA = 32'h0;
   end
   // One word transfer; released lines flip so stale data never matches
   task automatic xfer(input logic w, input logic [5:0] idx,
                       input logic [31:0] wd, output logic [31:0] rd);
      @(posedge MCLK);
      HSEL <= 1'b1;
      HADDR <= {24'h0, idx, cgir_pkg::ADDR_LOW_ZERO};
      HTRANS <= cgir_pkg::HTRANS_NONSEQ;
      HWRITE <= w;
      @(posedge MCLK);
      while (HREADY !== 1'b1) @(posedge MCLK);
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HADDR <= ~HADDR;
      HWDATA <= w ? wd : ~HWDATA;
      @(posedge MCLK);
      while (HREADY !== 1'b1) @(posedge MCLK);
      rd = HRDATA;
      HWDATA <= ~HWDATA;
   endtask
endmodule
`default_nettype wire

// *** tb/cgir_properties.sv ***
// Concurrent checks on the register bank ports
`timescale 1ns/1ps
`default_nettype none
module cgir_properties #(
   parameter int PAIRS = 3
) (
   // Clock and reset
   input wire logic MCLK,
   input wire logic ARST_N,
   // Bus
   input wire logic CE,
   input wire logic HSEL,
   input wire logic [1:0] HTRANS,
   input wire logic HREADY,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   // Pins and outputs
   input wire logic HOST_STOP,
   input wire logic MGMT_M1,
   input wire logic SE_A_ENABLE,
   input wire logic SE_B_ENABLE,
   input wire logic REF_DOUBLE_DRIVE,
   input wire logic [2:0] IO_VOLT_CODE,
   input wire logic [PAIRS-1:0] PAIR_RUN
);
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!ARST_N);
   // Accepted request and its single wait state
   sequence taken_s;
      CE && HSEL && HREADY && HTRANS == cgir_pkg::HTRANS_NONSEQ;
   endsequence
   sequence wait_s;
      !HREADYOUT ##1 HREADYOUT;
   endsequence
   okay_resp_a: assert property (HRESP == cgir_pkg::HRESP_OKAY)
      else $error("bus response not okay");
   wait_state_a: assert property (taken_s |=> wait_s)
      else $error("request not answered after one wait");
   ready_back_a: assert property (!HREADYOUT |=> HREADYOUT)
      else $error("ready held low too long");
   // Reset values seen at the first edge after release
   se_reset_a: assert property ($rose(ARST_N) |->
      !SE_A_ENABLE && !SE_B_ENABLE) else $error("output enable reset");
   ref_reset_a: assert property ($rose(ARST_N) |-> REF_DOUBLE_DRIVE)
      else $error("drive strength reset");
   volt_reset_a: assert property ($rose(ARST_N) |->
      IO_VOLT_CODE == 3'h5) else $error("voltage code reset");
   pair_reset_a: assert property ($rose(ARST_N) |->
      PAIR_RUN == {PAIRS{1'b1}}) else $error("pairs not running");
   // Sync plus output flop settle inside five cycles
   free_run_a: assert property ((!HOST_STOP && !MGMT_M1) [*5] |->
      PAIR_RUN == {PAIRS{1'b1}}) else $error("pair stopped");
endmodule
bind cgir_regs cgir_properties #(.PAIRS(PAIRS)) cgir_properties_i (
   .MCLK(MCLK), .ARST_N(ARST_N), .CE(CE), .HSEL(HSEL), .HTRANS(HTRANS),
   .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
   .HOST_STOP(HOST_STOP), .MGMT_M1(MGMT_M1), .SE_A_ENABLE(SE_A_ENABLE),
   .SE_B_ENABLE(SE_B_ENABLE), .REF_DOUBLE_DRIVE(REF_DOUBLE_DRIVE),
   .IO_VOLT_CODE(IO_VOLT_CODE), .PAIR_RUN(PAIR_RUN));
`default_nettype wire

// *** tb/clock_gen_id_control_regs_tb.sv ***
// Self-checking bench for the identity and control registers
`timescale 1ns/1ps
`default_nettype none
module clock_gen_id_control_regs_tb;
   logic mclk, arst_n, ce, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, d, e;
   logic [1:0] htrans;
   logic [2:0] hsize, io_volt;
   logic trusted, sref5, tmode, tsel, pstop, hstop, m1;
   logic se_a, se_b, ph5, refd, tm, tdiv;
   logic [2:0] pair_run;
   wire logic [11:0] outs;
   int errors, tests_run, cycles, i;
   // Expected bytes 7..12: reset, after all ones, after all zeros
   logic [7:0] rstv [6] = '{8'h29, 8'h50, 8'h65, 8'h83, 8'h05, 8'h0d};
   logic [7:0] onev [6] = '{8'h29, 8'h5f, 8'hff, 8'hff, 8'hfd, 8'hff};
   logic [7:0] zerv [6] = '{8'h29, 8'h50, 8'h40, 8'h80, 8'h00, 8'h00};
   assign outs = {se_a, se_b, ph5, refd, tm, tdiv, io_volt, pair_run};
   // Revision 2, vendor 9, variant 5: arbitrary values
   cgir_regs #(.REVISION_CODE(4'h2), .VENDOR_CODE(4'h9),
      .VARIANT_CODE(4'h5)) cgir_regs_i (.MCLK(mclk), .ARST_N(arst_n),
      .CE(ce), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
      .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata),
      .TRUSTED_STRAP(trusted), .SREF5_STRAP(sref5),
      .TEST_MODE_STRAP(tmode), .TEST_SEL_STRAP(tsel), .PERIPH_STOP(pstop),
      .HOST_STOP(hstop), .MGMT_M1(m1), .SE_A_ENABLE(se_a),
      .SE_B_ENABLE(se_b), .PERIPH5_HALT(ph5), .PAIR_RUN(pair_run),
      .REF_DOUBLE_DRIVE(refd), .TEST_MODE_ACTIVE(tm),
      .TEST_OUT_DIVIDED(tdiv), .IO_VOLT_CODE(io_volt));
   cgir_host cgir_host_i (.MCLK(mclk), .HREADY(hreadyout), .HRDATA(hrdata),
      .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
      .HSIZE(hsize), .HWDATA(hwdata));
   always #5 mclk = ~mclk;
   // Hang guard well above the run length
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         errors++;
         $display("mismatch at %0t: timeout", $time);
         print_verdict;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [5:0] idx, input logic [7:0] v);
      logic [31:0] dummy;
      cgir_host_i.xfer(1'b1, idx, {24'h0, v}, dummy);
   endtask
   task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
      cgir_host_i.xfer(1'b0, idx, 32'h0, d);
      chk(d, exp);
   endtask
   // Output flops settle, pins need sync plus output flop
   task automatic outchk(input int n, input logic [11:0] exp);
      repeat (n) @(posedge mclk);
      chk({20'h0, outs}, {20'h0, exp});
   endtask
   task automatic tend(input string name);
      $display("test %s done", name);
   endtask
   task print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {mclk, arst_n, tmode, tsel, pstop, hstop, m1} = 7'h0;
      {ce, trusted, sref5} = 3'h7;
      {errors, tests_run, cycles} = 0;
      repeat (20) @(posedge mclk);
      arst_n <= 1'b1;
      for (i = 0; i < 6; i++) begin
         rd(cgir_pkg::IDX_VENDOR_REV + 6'(i), rstv[i]);
      end
      tend("reset values");
      for (i = 0; i < 6; i++) wr(cgir_pkg::IDX_VENDOR_REV + 6'(i), 8'hff);
      for (i = 0; i < 6; i++) begin
         rd(cgir_pkg::IDX_VENDOR_REV + 6'(i), onev[i]);
      end
      outchk(1, 12'hdff);
      pstop <= 1'b1;
      outchk(4, 12'hfff);
      tend("all ones");
      wr(cgir_pkg::IDX_BYTE_COUNT, 8'h09);
      wr(cgir_pkg::IDX_BLOCK_READ, 8'h00);
      // Bytes 0..6 read zero, byte 8 carries the last flag, then wrap
      for (i = 0; i < 10; i++) begin
         e = i == 7 ? 32'h29 : i == 8 ? 32'h15f : 32'h0;
         rd(cgir_pkg::IDX_BLOCK_READ, e);
      end
      tend("block read");
      for (i = 0; i < 6; i++) wr(cgir_pkg::IDX_VENDOR_REV + 6'(i), 8'h00);
      for (i = 0; i < 6; i++) begin
         rd(cgir_pkg::IDX_VENDOR_REV + 6'(i), zerv[i]);
      end
      outchk(1, 12'h007);
      tmode <= 1'b1;
      tsel <= 1'b1;
      outchk(4, 12'h0c7);
      tmode <= 1'b0;
      tsel <= 1'b0;
      tend("all zeros");
      hstop <= 1'b1;
      m1 <= 1'b1;
      outchk(4, 12'h001);
      wr(cgir_pkg::IDX_HOST_STOP, 8'h03);
      wr(cgir_pkg::IDX_MGMT, 8'h08);
      outchk(1, 12'h004);
      tend("pair control");
      wr(6'h20, 8'hff);
      rd(6'h20, 32'h0);
      tend("unmapped");
      arst_n <= 1'b0;
      repeat (3) @(posedge mclk);
      arst_n <= 1'b1;
      // Straps reach their latches only once the synchroniser has filled
      repeat (3) @(posedge mclk);
      rd(cgir_pkg::IDX_OUT_CTRL, 32'h65);
      rd(cgir_pkg::IDX_MGMT, 32'h05);
      tend("second reset");
      print_verdict;
   end
endmodule
`default_nettype wire
